// ---- design/lacl_top.sv ----
// Top of the load-adaptive coil current loop with its register file.
// Assumes halfCycle and loadRaw come from pins, sampled here.
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module lacl_top (
   // Clocking
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Avalon-MM slave
   input wire logic [9:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Motor side
   input wire logic halfCycle,
   input wire logic [10:0] loadRaw,
   output logic [7:0] currentRef,
   output logic learnBusy
);
   logic [7:0] floorHi_ff, bandUp_ff, bandLo_ff, kp_ff, kd_ff;
   logic [7:0] ctrl_ff, floor_ff, ceil_ff, dac_ff;
   logic [10:0] learned_ff;
   logic [10:0] cnt;
   logic [1:0] hcSync_ff;
   logic hcPrev_ff;
   logic [10:0] rawS1_ff, rawS2_ff;
   logic hcStb;
   logic ack_ff;
   logic [7:0] idx;
   logic wrHit;
   logic [2:0] hold_ff;
   logic [4:0] dwell_ff;
   lacl_pkg::lacl_lrn_e lrn_ff;
   logic lrnDone;
   logic apply_ff;
   logic signed [12:0] err;
   logic signed [12:0] corr;
   logic signed [13:0] nxt_dac;

   // Byte address to register index
   function automatic logic [7:0] regIdx(input logic [9:0] a);
      return a[9:2];
   endfunction

   assign idx = regIdx(avs_address);
   // Writes land on the edge where waitrequest is seen low
   assign wrHit = avs_write && ack_ff;

   // Pin inputs pass two flops before use
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hcSync_ff <= 2'h0;
         hcPrev_ff <= 1'b0;
         rawS1_ff <= 11'h000;
         rawS2_ff <= 11'h000;
      end else if (ce) begin
         hcSync_ff <= {hcSync_ff[0], halfCycle};
         hcPrev_ff <= hcSync_ff[1];
         rawS1_ff <= loadRaw;
         rawS2_ff <= rawS1_ff;
      end
   end

   // Either edge marks a new electrical half-cycle
   assign hcStb = hcSync_ff[1] ^ hcPrev_ff;

   // One wait state: answer on second cycle of each request
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ack_ff <= 1'b0;
      end else if (ce) begin
         ack_ff <= (avs_read || avs_write) && !ack_ff;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
      end else if (ce) begin
         avs_waitrequest <= !((avs_read || avs_write) && !ack_ff);
      end
   end

   // Plain configuration registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         floorHi_ff <= lacl_pkg::RST_FLOOR_HI;
         bandUp_ff <= lacl_pkg::RST_ZERO;
         bandLo_ff <= lacl_pkg::RST_ZERO;
         kp_ff <= lacl_pkg::RST_ZERO;
         kd_ff <= lacl_pkg::RST_ZERO;
         floor_ff <= lacl_pkg::RST_FLOOR;
         ceil_ff <= lacl_pkg::RST_CEIL;
      end else if (ce && wrHit) begin
         unique case (idx)
            lacl_pkg::IDX_FLOOR_HI: floorHi_ff <= avs_writedata[7:0];
            lacl_pkg::IDX_BAND_UP: bandUp_ff <= avs_writedata[7:0];
            lacl_pkg::IDX_BAND_LO: bandLo_ff <= avs_writedata[7:0];
            lacl_pkg::IDX_KP: kp_ff <= avs_writedata[7:0];
            // Reserved bits written but kept stored
            lacl_pkg::IDX_KD: kd_ff <= avs_writedata[7:0];
            lacl_pkg::IDX_FLOOR: floor_ff <= avs_writedata[7:0];
            lacl_pkg::IDX_CEIL: ceil_ff <= avs_writedata[7:0];
            default: ;
         endcase
      end
   end

   // Control: trigger set by software wins over completion clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_ff <= lacl_pkg::RST_CTRL;
      end else if (ce) begin
         if (wrHit && idx == lacl_pkg::IDX_CTRL) begin
            ctrl_ff <= avs_writedata[7:0];
         end else if (lrnDone) begin
            ctrl_ff[lacl_pkg::TRIG_BIT] <= 1'b0;
         end
      end
   end

   // Learning: dwell at initial level, then at final, recording counts
   assign lrnDone = (lrn_ff == lacl_pkg::LS_HIGH) && hcStb &&
      dwell_ff == 5'h00;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lrn_ff <= lacl_pkg::LS_IDLE;
         dwell_ff <= 5'h00;
         learned_ff <= 11'h000;
      end else if (ce) begin
         // Software may preset the parameter; learning overwrites it
         if (wrHit && idx == lacl_pkg::IDX_FLOOR_HI) begin
            learned_ff[10:8] <= avs_writedata[2:0];
         end
         if (wrHit && idx == lacl_pkg::IDX_CONST_LO) begin
            learned_ff[7:0] <= avs_writedata[7:0];
         end
         unique case (lrn_ff)
            lacl_pkg::LS_IDLE: begin
               if (ctrl_ff[lacl_pkg::TRIG_BIT]) begin
                  lrn_ff <= lacl_pkg::LS_LOW;
                  dwell_ff <= lacl_pkg::LRN_DWELL;
               end
            end
            lacl_pkg::LS_LOW: begin
               if (hcStb) begin
                  if (dwell_ff == 5'h00) begin
                     lrn_ff <= lacl_pkg::LS_HIGH;
                     dwell_ff <= lacl_pkg::LRN_DWELL;
                  end else begin
                     dwell_ff <= dwell_ff - 5'h01;
                  end
               end
            end
            lacl_pkg::LS_HIGH: begin
               if (hcStb) begin
                  if (dwell_ff == 5'h00) begin
                     lrn_ff <= lacl_pkg::LS_IDLE;
                     learned_ff <= cnt;
                  end else begin
                     dwell_ff <= dwell_ff - 5'h01;
                  end
               end
            end
            default: lrn_ff <= lacl_pkg::LS_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         learnBusy <= 1'b0;
      end else if (ce) begin
         learnBusy <= lrn_ff != lacl_pkg::LS_IDLE;
      end
   end

   lacl_avg u_avg (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .smpStb(hcStb),
      .smpIn(rawS2_ff),
      .depthCode(ctrl_ff[lacl_pkg::AVG_MSB:0]),
      .avgOut(cnt)
   );

   // Error from band edge; zero inside the band
   always_comb begin
      if (cnt > {3'h0, bandUp_ff}) begin
         err = 13'(cnt) - 13'(bandUp_ff);
      end else if (cnt < {3'h0, bandLo_ff}) begin
         err = 13'(cnt) - 13'(bandLo_ff);
      end else begin
         err = 13'h0000;
      end
   end

   // Hold counter: loop acts every N half-cycles
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hold_ff <= 3'h1;
      end else if (ce && hcStb) begin
         if (hold_ff <= 3'h1) begin
            hold_ff <= ctrl_ff[lacl_pkg::HOLD_MSB:lacl_pkg::HOLD_LSB];
         end else begin
            hold_ff <= hold_ff - 3'h1;
         end
      end
   end

   // Correction lands once per loop step, and only outside the band
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         apply_ff <= 1'b0;
      end else if (ce) begin
         apply_ff <= hcStb && (hold_ff <= 3'h1) && err != 13'h0000;
      end
   end

   lacl_pd u_pd (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .stepStb(hcStb && hold_ff <= 3'h1),
      .err(err),
      .kp(kp_ff),
      .kd(kd_ff[lacl_pkg::KD_MSB:0]),
      .corr(corr)
   );

   // Reference: learn levels, clamp, or ceiling when disabled
   // Signed clamp: a deep cut lands on the floor, not the ceiling
   always_comb begin
      nxt_dac = 14'({6'h00, dac_ff});
      if (apply_ff) begin
         nxt_dac = nxt_dac + 14'(corr);
      end
      if (lrn_ff == lacl_pkg::LS_LOW) begin
         nxt_dac = 14'({floorHi_ff[lacl_pkg::LVL_MSB:lacl_pkg::LVL_LSB],
            3'h0});
      end else if (lrn_ff == lacl_pkg::LS_HIGH) begin
         nxt_dac = 14'(ceil_ff);
      end else if (nxt_dac > $signed({6'h00, ceil_ff})) begin
         nxt_dac = 14'(ceil_ff);
      end else if (nxt_dac < $signed({6'h00, floor_ff})) begin
         nxt_dac = 14'(floor_ff);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dac_ff <= lacl_pkg::RST_CEIL;
      end else if (ce) begin
         if (!ctrl_ff[lacl_pkg::EN_BIT] && lrn_ff == lacl_pkg::LS_IDLE) begin
            dac_ff <= ceil_ff;
         end else begin
            dac_ff <= nxt_dac[7:0];
         end
      end
   end

   assign currentRef = dac_ff;

   // Read mux, registered; unmapped reads zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (ce && avs_read && !ack_ff) begin
         unique case (idx)
            lacl_pkg::IDX_CNT_LO: avs_readdata <= {24'h0, cnt[7:0]};
            lacl_pkg::IDX_CNT_HI: avs_readdata <= {24'h0, cnt[10:8], 5'h00};
            lacl_pkg::IDX_FLOOR_HI: avs_readdata <= {24'h0,
               floorHi_ff[7:3], learned_ff[10:8]};
            lacl_pkg::IDX_CONST_LO: avs_readdata <= {24'h0, learned_ff[7:0]};
            lacl_pkg::IDX_BAND_UP: avs_readdata <= {24'h0, bandUp_ff};
            lacl_pkg::IDX_BAND_LO: avs_readdata <= {24'h0, bandLo_ff};
            lacl_pkg::IDX_KP: avs_readdata <= {24'h0, kp_ff};
            lacl_pkg::IDX_KD: avs_readdata <= {24'h0, kd_ff};
            lacl_pkg::IDX_CTRL: avs_readdata <= {24'h0, ctrl_ff};
            lacl_pkg::IDX_FLOOR: avs_readdata <= {24'h0, floor_ff};
            lacl_pkg::IDX_CEIL: avs_readdata <= {24'h0, ceil_ff};
            lacl_pkg::IDX_DAC: avs_readdata <= {24'h0, dac_ff};
            default: avs_readdata <= 32'h0000_0000;
         endcase
      end
   end
endmodule

// ---- design/lacl_pkg.sv ----
// Package for the load-adaptive coil current loop.
// Assumes an Avalon-MM slave with word addressing by byte address/4.
package lacl_pkg;
   // Register indices as printed; byte address is index times four
   localparam logic [7:0] IDX_FLOOR_HI = 8'h22;
   localparam logic [7:0] IDX_CONST_LO = 8'h23;
   localparam logic [7:0] IDX_BAND_UP = 8'h24;
   localparam logic [7:0] IDX_BAND_LO = 8'h25;
   localparam logic [7:0] IDX_KP = 8'h26;
   localparam logic [7:0] IDX_KD = 8'h27;
   localparam logic [7:0] IDX_CTRL = 8'h28;
   localparam logic [7:0] IDX_FLOOR = 8'h29;
   // Extra registers: count, ceiling, output readback
   localparam logic [7:0] IDX_CNT_LO = 8'h1f;
   localparam logic [7:0] IDX_CNT_HI = 8'h20;
   localparam logic [7:0] IDX_CEIL = 8'h2a;
   localparam logic [7:0] IDX_DAC = 8'h2e;
   // Reset values
   localparam logic [7:0] RST_FLOOR_HI = 8'h20;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_CTRL = 8'h08;
   localparam logic [7:0] RST_FLOOR = 8'h0a;
   localparam logic [7:0] RST_CEIL = 8'hff;
   // Field positions
   localparam int LVL_MSB = 7;
   localparam int LVL_LSB = 3;
   localparam int LRN_HI_MSB = 2;
   localparam int KD_MSB = 3;
   localparam int EN_BIT = 7;
   localparam int TRIG_BIT = 6;
   localparam int HOLD_MSB = 5;
   localparam int HOLD_LSB = 3;
   localparam int AVG_MSB = 2;
   localparam int LVL_SHIFT = 3;
   // Averaging codes
   localparam logic [2:0] AVG_2 = 3'h2;
   localparam logic [2:0] AVG_4 = 3'h4;
   localparam logic [2:0] AVG_8 = 3'h7;
   // Learning dwell: each level is held for this count plus one half-cycles
   localparam logic [4:0] LRN_DWELL = 5'h08;
   typedef enum logic [1:0] {
      LS_IDLE = 2'b00,
      LS_LOW = 2'b01,
      LS_HIGH = 2'b10
   } lacl_lrn_e;
endpackage

// ---- design/lacl_avg.sv ----
// Moving average of the raw load count over 1, 2, 4 or 8 half-cycles.
// Assumes one sample strobe per electrical half-cycle.
`timescale 1ns/1ps
module lacl_avg (
   // Clocking
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Samples
   input wire logic smpStb,
   input wire logic [10:0] smpIn,
   input wire logic [2:0] depthCode,
   // Result
   output logic [10:0] avgOut
);
   logic [10:0] hist_ff [8];
   logic [13:0] sum;
   logic [2:0] shift;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 8; i++) begin
            hist_ff[i] <= 11'h000;
         end
      end else if (ce && smpStb) begin
         hist_ff[0] <= smpIn;
         for (int i = 1; i < 8; i++) begin
            hist_ff[i] <= hist_ff[i-1];
         end
      end
   end

   // Depth decode: unlisted codes give no averaging
   always_comb begin
      unique case (depthCode)
         lacl_pkg::AVG_2: shift = 3'h1;
         lacl_pkg::AVG_4: shift = 3'h2;
         lacl_pkg::AVG_8: shift = 3'h3;
         default: shift = 3'h0;
      endcase
      sum = 14'h0000;
      for (int i = 0; i < 8; i++) begin
         if (i < (1 << shift)) begin
            sum = sum + {3'h0, hist_ff[i]};
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         avgOut <= 11'h000;
      end else if (ce) begin
         avgOut <= 11'(sum >> shift);
      end
   end
endmodule

// ---- design/lacl_pd.sv ----
// PD correction step for the coil current reference.
// Assumes error and its change are signed, scaled down by 16.
`timescale 1ns/1ps
module lacl_pd (
   // Clocking
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Loop inputs
   input wire logic stepStb,
   input wire logic signed [12:0] err,
   input wire logic [7:0] kp,
   input wire logic [3:0] kd,
   // Correction
   output logic signed [12:0] corr
);
   logic signed [12:0] prevErr_ff;
   logic signed [13:0] dErr;
   logic signed [25:0] acc;
   logic signed [21:0] scaled;
   logic signed [12:0] sat;

   // Saturate rather than wrap: a wrapped sign would flip the step
   always_comb begin
      dErr = 14'(err) - 14'(prevErr_ff);
      acc = 26'(err) * $signed({1'b0, kp}) + 26'(dErr) * $signed({1'b0, kd});
      scaled = 22'(acc >>> 4);
      if (scaled > 22'sh000fff) begin
         sat = 13'sh0fff;
      end else if (scaled < 22'sh3ff000) begin
         sat = 13'sh1000;
      end else begin
         sat = 13'(scaled);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prevErr_ff <= 13'h0000;
         corr <= 13'h0000;
      end else if (ce && stepStb) begin
         prevErr_ff <= err;
         corr <= sat;
      end
   end
endmodule

// ---- sim/lacl_assertions.sv ----
// Port checker for the coil current loop top.
// Assumes ce stays high; keeps shadows of a few registers from bus writes.
`timescale 1ns/1ps
module lacl_assertions (
   // Clocking
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Bus
   input wire logic [9:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // Motor side
   input wire logic [7:0] currentRef,
   input wire logic learnBusy
);
   logic [7:0] floor_ff;
   logic [7:0] ceil_ff;
   logic en_ff;
   logic wrAck;
   logic [7:0] idx;
   assign wrAck = avs_write && !avs_waitrequest && ce;
   assign idx = avs_address[9:2];
   // Shadows, since the register file is out of sight here
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         floor_ff <= lacl_pkg::RST_FLOOR;
         ceil_ff <= lacl_pkg::RST_CEIL;
         en_ff <= 1'b0;
      end else if (wrAck) begin
         if (idx == lacl_pkg::IDX_FLOOR)
            floor_ff <= avs_writedata[7:0];
         if (idx == lacl_pkg::IDX_CEIL)
            ceil_ff <= avs_writedata[7:0];
         if (idx == lacl_pkg::IDX_CTRL)
            en_ff <= avs_writedata[7];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   chk_wait_answer: assert property (
      (avs_read || avs_write) && avs_waitrequest && ce |=> !avs_waitrequest)
      else $error("request not answered after one wait cycle");
   chk_idle_no_ack: assert property (
      !avs_read && !avs_write |=> avs_waitrequest)
      else $error("answer without a request");
   chk_rdata_upper: assert property (
      !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
      else $error("upper read data bits not zero");
   chk_rdata_hold: assert property (
      !(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
      else $error("read data changed without a read");
   chk_floor_kept: assert property (
      en_ff && $past(en_ff) && $stable(floor_ff) && $stable(ceil_ff)
      && floor_ff <= ceil_ff && !learnBusy && !$past(learnBusy)
      |-> currentRef >= floor_ff)
      else $error("current reference below floor");
   chk_ceil_kept: assert property (
      en_ff && $past(en_ff) && $stable(ceil_ff) && !learnBusy
      && !$past(learnBusy) |-> currentRef <= ceil_ff)
      else $error("current reference above ceiling");
   chk_off_ceiling: assert property (
      !en_ff && !$past(en_ff) && $stable(ceil_ff) && !learnBusy
      && !$past(learnBusy) |-> currentRef == ceil_ff)
      else $error("disabled loop does not show ceiling");
   chk_learn_start: assert property (
      wrAck && idx == lacl_pkg::IDX_CTRL && avs_writedata[6]
      |-> ##[1:3] learnBusy)
      else $error("learning did not start");
endmodule

bind lacl_top lacl_assertions chkInst (.clk(clk), .rst(rst), .ce(ce),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .currentRef(currentRef),
   .learnBusy(learnBusy));

// ---- sim/testbench.sv ----
// Self-checking bench for the coil current loop top.
// Assumes one wait cycle per bus request and ce held high.
`timescale 1ns/1ps
module testbench;
   localparam logic [7:0] RIDX [10] = '{8'h22, 8'h23, 8'h24, 8'h25, 8'h26,
      8'h27, 8'h28, 8'h29, 8'h2a, 8'h2e};
   localparam logic [7:0] RVAL [10] = '{8'h20, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h08, 8'h0a, 8'hff, 8'hff};
   localparam logic [7:0] WIDX [6] = '{8'h24, 8'h25, 8'h26, 8'h27, 8'h28,
      8'h29};
   localparam logic [7:0] WVAL [6] = '{8'ha5, 8'h5a, 8'hc3, 8'h07, 8'h3a,
      8'h30};
   localparam logic [2:0] ACODE [5] = '{3'h0, 3'h2, 3'h4, 3'h7, 3'h3};
   localparam logic [10:0] AEXP [5] = '{11'h400, 11'h200, 11'h100, 11'h080,
      11'h400};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic [9:0] avsAddress = 10'h000;
   logic avsRead = 1'b0;
   logic avsWrite = 1'b0;
   logic [31:0] avsWritedata = 32'h00000000;
   logic [31:0] avsReaddata;
   logic avsWaitrequest;
   logic halfCycle = 1'b0;
   logic [10:0] loadRaw = 11'h000;
   logic [7:0] currentRef;
   logic learnBusy;
   logic [7:0] rdat;
   logic [7:0] hi;
   int numErrors = 0;
   int comparisons = 0;
   int n;
   always #5 clk = ~clk;
   lacl_top dut (.clk(clk), .rst(rst), .ce(ce), .avs_address(avsAddress),
      .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
      .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest),
      .halfCycle(halfCycle), .loadRaw(loadRaw), .currentRef(currentRef),
      .learnBusy(learnBusy));
   task automatic print_verdict();
      $display("Comparisons %0d, errors %0d", comparisons, numErrors);
      if (numErrors == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         numErrors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Entered just after a rising edge; holds the request until acked
   task automatic xfer(input logic wr, input logic [7:0] idx,
      input logic [7:0] wd, output logic [7:0] rd);
      int k;
      k = 0;
      avsAddress <= {idx, 2'b00};
      avsWrite <= wr;
      avsRead <= !wr;
      avsWritedata <= {24'h000000, wd};
      do begin
         @(posedge clk);
         k++;
      end while (avsWaitrequest !== 1'b0 && k < 40);
      rd = avsReaddata[7:0];
      avsWrite <= 1'b0;
      avsRead <= 1'b0;
      if (k >= 40) begin
         numErrors++;
         $display("ERROR %0t: no bus answer", $time);
      end
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] t;
      xfer(1'b1, idx, d, t);
   endtask
   task automatic rdChk(input logic [7:0] idx, input logic [7:0] exp);
      logic [7:0] t;
      xfer(1'b0, idx, 8'h00, t);
      check8(t, exp);
   endtask
   // Load set well before the edge so the two-flop sampler sees it
   task automatic half(input logic [10:0] load);
      loadRaw <= load;
      repeat (4) @(posedge clk);
      halfCycle <= ~halfCycle;
      repeat (8) @(posedge clk);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 10; i++) begin
         rdChk(RIDX[i], RVAL[i]);
      end
      for (int i = 0; i < 6; i++) begin
         wr(WIDX[i], WVAL[i]);
         rdChk(WIDX[i], WVAL[i]);
      end
      wr(8'h22, 8'hfb);
      xfer(1'b0, 8'h22, 8'h00, rdat);
      check8(rdat & 8'hf8, 8'hf8);
      wr(8'h21, 8'h55);
      rdChk(8'h21, 8'h00);
      rdChk(8'h30, 8'h00);
      wr(8'h2a, 8'h80);
      repeat (2) @(posedge clk);
      check8(currentRef, 8'h80);
      rdChk(8'h2e, 8'h80);
      // A single spike after zeros shows the averaging depth
      for (int c = 0; c < 5; c++) begin
         wr(8'h28, {5'b00001, ACODE[c]});
         repeat (8) half(11'h000);
         half(11'h400);
         xfer(1'b0, 8'h1f, 8'h00, rdat);
         xfer(1'b0, 8'h20, 8'h00, hi);
         check8(rdat, AEXP[c][7:0]);
         check8(hi & 8'he0, {AEXP[c][10:8], 5'h00});
      end
      wr(8'h29, 8'h40);
      wr(8'h2a, 8'hc0);
      wr(8'h24, 8'h10);
      wr(8'h25, 8'h08);
      wr(8'h26, 8'hff);
      wr(8'h27, 8'h0f);
      wr(8'h28, 8'h88);
      for (int i = 0; i < 24; i++) begin
         half(i[2] ? 11'h7ff : 11'h000);
         check8({7'h00, currentRef >= 8'h40 && currentRef <= 8'hc0},
            8'h01);
         if (i[1:0] == 2'h3) begin
            check8(currentRef, i[2] ? 8'hc0 : 8'h40);
         end
      end
      // Step into the band from below: the floor must hold
      half(11'h000);
      repeat (3) half(11'h00c);
      check8(currentRef, 8'h40);
      wr(8'h28, 8'hc8);
      n = 0;
      do begin
         half(11'h100);
         xfer(1'b0, 8'h28, 8'h00, rdat);
         n++;
      end while (rdat[6] === 1'b1 && n < 40);
      check8(rdat & 8'h40, 8'h00);
      check8({7'h00, n >= 16}, 8'h01);
      check8({7'h00, learnBusy}, 8'h00);
      xfer(1'b0, 8'h22, 8'h00, rdat);
      check8(rdat & 8'h07, 8'h01);
      rdChk(8'h23, 8'h00);
      wr(8'h23, 8'h5a);
      rdChk(8'h23, 8'h5a);
      print_verdict();
   end
   // Whole run needs under fifteen hundred cycles; this leaves ample margin
   initial begin
      repeat (20000) @(posedge clk);
      numErrors++;
      $display("ERROR %0t: watchdog expired", $time);
      print_verdict();
   end
endmodule
